// file: mwl_pkg.sv
// shared offsets, field positions and reset values of the window latch block
package mwl_pkg;
  // register offsets
  localparam logic [7:0] OUT_SRC_ADDR = 8'h2d;
  localparam logic [7:0] IN_SRC_ADDR  = 8'h2e;
  localparam logic [7:0] CFG_ADDR     = 8'h2f;
  // configuration fields
  localparam int CFG_OUT_LATCH = 7;
  localparam int CFG_IN_LATCH  = 6;
  localparam int CFG_OUT_EN_LO = 3;
  localparam int CFG_IN_EN_LO  = 0;
  // source register fields: event active on top, axis flags on odd bits
  localparam int SRC_EA        = 7;
  localparam int SRC_X         = 5;
  localparam int SRC_Y         = 3;
  localparam int SRC_Z         = 1;
  // configuration reset values, chosen by the boot strap, and the unmapped read value
  localparam logic [7:0] CFG_RST_LOW  = 8'h00;
  localparam logic [7:0] CFG_RST_HIGH = 8'h38;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;
endpackage

// file: mwl_dbnc_if.sv
// debounce request and answer between the latch block and its counter
`timescale 1ns/1ns
interface mwl_dbnc_if #(parameter int CW = 8);
  logic          tick;
  logic          cond;
  logic [CW-1:0] limit;
  logic          reached;
  modport cnt  (input tick, input cond, input limit, output reached);
  modport user (output tick, output cond, output limit, input reached);
endinterface

// file: mwl_debounce.sv
// sample-cycle debounce counter for one window condition
`timescale 1ns/1ns
module mwl_debounce #(
  parameter int CW = 8
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // request and answer
  mwl_dbnc_if.cnt   db
);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [CW:0]   cnt_inc;

  // the count saturates so a long condition never wraps back to zero
  always_comb begin
    cnt_inc = {1'b0, cnt_ff} + {{CW{1'b0}}, 1'b1};
    nxt_cnt = cnt_ff;
    if (db.tick) begin
      if (!db.cond) begin
        nxt_cnt = '0;
      end else if (!cnt_inc[CW]) begin
        nxt_cnt = cnt_inc[CW-1:0];
      end
    end
  end

  // counts the present sample too, so a limit of zero passes at once
  assign db.reached = db.cond && (cnt_inc >= {1'b0, db.limit});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// file: mwl_latch.sv
// window event flag latching and axis selection with its register port
`timescale 1ns/1ns
module mwl_latch #(
  parameter int DW = 12,
  parameter int CW = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // boot strap level
  input  wire logic          boot_strap_select,
  // register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  // sample data and detector settings
  input  wire logic          sample_tick,
  input  wire logic [DW-1:0] x_data,
  input  wire logic [DW-1:0] y_data,
  input  wire logic [DW-1:0] z_data,
  input  wire logic [DW-1:0] upper_threshold,
  input  wire logic [DW-1:0] lower_threshold,
  input  wire logic [CW-1:0] inside_debounce_count,
  input  wire logic [CW-1:0] outside_debounce_count,
  input  wire logic          inside_logic_select,
  // event outputs and configuration mirror
  output logic               inside_window_event_active,
  output logic               outside_window_event_active,
  output logic      [2:0]    axis_inside_window_flags,
  output logic      [2:0]    axis_outside_window_flags,
  output logic      [7:0]    change_detect_axis_latch_config
);
  // signed window test shared by all three axes
  function automatic logic in_window(input logic [DW-1:0] d,
                                     input logic [DW-1:0] u,
                                     input logic [DW-1:0] l);
    in_window = ($signed(d) < $signed(u)) && ($signed(d) > $signed(l));
  endfunction

  function automatic logic [7:0] src_word(input logic       ea,
                                          input logic [2:0] f);
    src_word = '0;
    src_word[mwl_pkg::SRC_EA] = ea;
    src_word[mwl_pkg::SRC_X]  = f[2];
    src_word[mwl_pkg::SRC_Y]  = f[1];
    src_word[mwl_pkg::SRC_Z]  = f[0];
  endfunction

  logic [7:0] cfg_ff;
  logic [7:0] nxt_cfg;
  logic       strap_done_ff;
  logic       nxt_strap_done;
  logic [2:0] in_flags_ff;
  logic [2:0] nxt_in_flags;
  logic [2:0] out_flags_ff;
  logic [2:0] nxt_out_flags;
  logic       in_ea_ff;
  logic       nxt_in_ea;
  logic       out_ea_ff;
  logic       nxt_out_ea;
  logic       in_arm_ff;
  logic       nxt_in_arm;
  logic       out_arm_ff;
  logic       nxt_out_arm;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  logic [2:0] axis_in;
  logic [2:0] axis_out;
  logic [2:0] in_en;
  logic [2:0] out_en;
  logic       in_latch;
  logic       out_latch;
  logic       in_cond;
  logic       out_cond;
  logic       in_qual;
  logic       out_qual;
  logic       rd_in_src;
  logic       rd_out_src;
  logic       in_rise;
  logic       out_rise;

  mwl_dbnc_if #(.CW(CW)) in_db ();
  mwl_dbnc_if #(.CW(CW)) out_db ();

  // bit order x, y, z from high to low matches the enable fields
  assign axis_in[2] = in_window(x_data, upper_threshold, lower_threshold);
  assign axis_in[1] = in_window(y_data, upper_threshold, lower_threshold);
  assign axis_in[0] = in_window(z_data, upper_threshold, lower_threshold);
  assign axis_out   = ~axis_in;

  assign in_en     = cfg_ff[mwl_pkg::CFG_IN_EN_LO +: 3];
  assign out_en    = cfg_ff[mwl_pkg::CFG_OUT_EN_LO +: 3];
  assign in_latch  = cfg_ff[mwl_pkg::CFG_IN_LATCH];
  assign out_latch = cfg_ff[mwl_pkg::CFG_OUT_LATCH];

  // disabled axes count as inside for all-logic and as absent for any-logic
  assign in_cond = (|in_en) && (inside_logic_select ?
                   &(axis_in | ~in_en) : |(axis_in & in_en));
  assign out_cond = |(axis_out & out_en);

  assign in_db.tick   = sample_tick;
  assign in_db.cond   = in_cond;
  assign in_db.limit  = inside_debounce_count;
  assign out_db.tick  = sample_tick;
  assign out_db.cond  = out_cond;
  assign out_db.limit = outside_debounce_count;

  mwl_debounce #(.CW(CW)) u_in_db (
    .clk (clk),
    .rst (rst),
    .db  (in_db.cnt)
  );

  mwl_debounce #(.CW(CW)) u_out_db (
    .clk (clk),
    .rst (rst),
    .db  (out_db.cnt)
  );

  assign in_qual  = sample_tick && in_db.reached;
  assign out_qual = sample_tick && out_db.reached;
  // the host must read axis flags before the source word; that read clears them when latching is on
  assign rd_in_src  = reg_rd && (reg_addr == mwl_pkg::IN_SRC_ADDR);
  assign rd_out_src = reg_rd && (reg_addr == mwl_pkg::OUT_SRC_ADDR);
  assign in_rise    = in_qual && in_arm_ff;
  assign out_rise   = out_qual && out_arm_ff;

  // configuration and read port
  always_comb begin
    nxt_cfg        = cfg_ff;
    nxt_strap_done = 1'b1;
    nxt_rdata      = rdata_ff;
    if (!strap_done_ff) begin
      nxt_cfg = boot_strap_select ? mwl_pkg::CFG_RST_HIGH
                                  : mwl_pkg::CFG_RST_LOW;
    end else if (reg_wr && (reg_addr == mwl_pkg::CFG_ADDR)) begin
      nxt_cfg = reg_wdata;
    end
    if (reg_rd) begin
      if (reg_addr == mwl_pkg::CFG_ADDR) begin
        nxt_rdata = cfg_ff;
      end else if (reg_addr == mwl_pkg::IN_SRC_ADDR) begin
        nxt_rdata = src_word(in_ea_ff, in_flags_ff);
      end else if (reg_addr == mwl_pkg::OUT_SRC_ADDR) begin
        nxt_rdata = src_word(out_ea_ff, out_flags_ff);
      end else begin
        nxt_rdata = mwl_pkg::RD_UNMAPPED;
      end
    end
  end

  // inside event and flags; a new capture wins over a clearing read
  always_comb begin
    nxt_in_ea    = in_ea_ff;
    nxt_in_arm   = in_arm_ff;
    nxt_in_flags = in_flags_ff;
    if (in_latch) begin
      if (in_rise) begin
        nxt_in_ea    = 1'b1;
        nxt_in_arm   = 1'b0;
        nxt_in_flags = axis_in;
      end else begin
        if (rd_in_src) begin
          nxt_in_ea    = 1'b0;
          nxt_in_flags = '0;
        end
        if (sample_tick && !in_db.reached) begin
          nxt_in_arm = 1'b1;
        end
      end
    end else begin
      nxt_in_arm = 1'b1;
      if (sample_tick) begin
        nxt_in_ea = in_db.reached;
        if (in_db.reached || (inside_debounce_count == '0)) begin
          nxt_in_flags = axis_in;
        end
      end
    end
  end

  // outside event and flags; latched flags gather until the source read
  always_comb begin
    nxt_out_ea    = out_ea_ff;
    nxt_out_arm   = out_arm_ff;
    nxt_out_flags = out_flags_ff;
    if (out_latch) begin
      if (rd_out_src) begin
        nxt_out_ea    = 1'b0;
        nxt_out_flags = '0;
      end
      if (out_rise) begin
        nxt_out_ea    = 1'b1;
        nxt_out_arm   = 1'b0;
        nxt_out_flags = nxt_out_flags | (axis_out & out_en);
      end else if (sample_tick && !out_db.reached) begin
        nxt_out_arm = 1'b1;
      end
    end else begin
      nxt_out_arm = 1'b1;
      if (sample_tick) begin
        nxt_out_ea    = out_db.reached;
        nxt_out_flags = axis_out & out_en;
      end
    end
  end

  // asynchronous reset loads constants; the strap is caught after release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ff        <= mwl_pkg::CFG_RST_LOW;
      strap_done_ff <= 1'b0;
      in_flags_ff   <= '0;
      out_flags_ff  <= '0;
      in_ea_ff      <= 1'b0;
      out_ea_ff     <= 1'b0;
      in_arm_ff     <= 1'b1;
      out_arm_ff    <= 1'b1;
      rdata_ff      <= '0;
    end else begin
      cfg_ff        <= nxt_cfg;
      strap_done_ff <= nxt_strap_done;
      in_flags_ff   <= nxt_in_flags;
      out_flags_ff  <= nxt_out_flags;
      in_ea_ff      <= nxt_in_ea;
      out_ea_ff     <= nxt_out_ea;
      in_arm_ff     <= nxt_in_arm;
      out_arm_ff    <= nxt_out_arm;
      rdata_ff      <= nxt_rdata;
    end
  end

  assign reg_rdata                       = rdata_ff;
  assign inside_window_event_active      = in_ea_ff;
  assign outside_window_event_active     = out_ea_ff;
  // a flag of a disabled inside axis carries no meaning and reads as raw
  assign axis_inside_window_flags        = in_flags_ff;
  assign axis_outside_window_flags       = out_flags_ff;
  assign change_detect_axis_latch_config = cfg_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cfg_write;
    strap_done_ff && reg_wr && (reg_addr == mwl_pkg::CFG_ADDR);
  endsequence

  sequence s_in_read;
    rd_in_src && !(in_latch && in_rise);
  endsequence

  a_cfg_write_back: assert property (
    s_cfg_write ##1 (reg_rd && reg_addr == mwl_pkg::CFG_ADDR)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("configuration read does not return written value");

  a_cfg_write_lands: assert property (
    s_cfg_write |=> cfg_ff == $past(reg_wdata))
    else $error("configuration write did not take effect");

  a_strap_reset_val: assert property (
    $rose(strap_done_ff) |-> cfg_ff == ($past(boot_strap_select) ?
      mwl_pkg::CFG_RST_HIGH : mwl_pkg::CFG_RST_LOW))
    else $error("configuration reset value ignores strap");

  a_in_latch_clear: assert property (
    (in_latch and s_in_read) |=> in_flags_ff == 3'h0 && !in_ea_ff)
    else $error("latched inside flags survive source read");

  a_in_read_old: assert property (
    rd_in_src |=> reg_rdata == src_word($past(in_ea_ff),
                                        $past(in_flags_ff)))
    else $error("inside source read lost pre-clear value");

  a_in_capture: assert property (
    in_latch && in_rise |=> in_ea_ff && in_flags_ff == $past(axis_in))
    else $error("inside flags not captured on event rise");

  a_in_hold: assert property (
    in_latch && !in_rise && !rd_in_src ##0 in_latch [*1]
    |=> $stable(in_flags_ff))
    else $error("latched inside flags changed without read");

  a_in_rearm: assert property (
    in_latch && in_ea_ff && !in_arm_ff && !(sample_tick && !in_db.reached)
    |=> !in_arm_ff)
    else $error("inside event re-armed while condition held");

  a_in_disabled: assert property (
    in_en == 3'h0 && sample_tick && !in_latch |=> !in_ea_ff)
    else $error("inside event with no axis enabled");

  a_out_mask: assert property (
    !out_latch && sample_tick |=> (out_flags_ff & ~$past(out_en)) == 3'h0)
    else $error("disabled axis reached outside flags");

  a_out_latch_keep: assert property (
    out_latch && out_flags_ff != 3'h0 && !rd_out_src
    |=> (out_flags_ff & $past(out_flags_ff)) == $past(out_flags_ff)
        || !out_latch)
    else $error("latched outside flag cleared without read");

  a_out_track: assert property (
    !out_latch && sample_tick |=> out_flags_ff == $past(axis_out & out_en))
    else $error("unlatched outside flags do not track");

  a_in_unlatched: assert property (
    !in_latch && sample_tick && inside_debounce_count == '0
    |=> in_flags_ff == $past(axis_in))
    else $error("unlatched inside flags missed update");
endmodule

// file: mwl_host.sv
// host model driving the register port of the window latch block
`timescale 1ns/1ns
module mwl_host (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  logic [7:0] rd_data;

  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    rd_data   = 8'h00;
  end

  // one-cycle write strobe; the slave never stalls
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // data stand from the cycle after the strobe until the next read, so take them there
  // callers wanting a latched flag look at it before this read
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    rd_data = reg_rdata;
  endtask
endmodule

// file: mwl_latch_tb_top.sv
// self-checking bench for the window event latch block
`timescale 1ns/1ns
module mwl_latch_tb_top;
  localparam logic [11:0] IN  = 12'h000;
  localparam logic [11:0] OUT = 12'h0c8;
  localparam logic [11:0] UP  = 12'h064;
  localparam logic [11:0] LO  = 12'hf9c;
  logic        clk, rst, strap, tick, lsel;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, cfg, idb, odb;
  logic        reg_wr, reg_rd, in_ea, out_ea;
  logic [11:0] xd, yd, zd, uth, lth;
  logic [2:0]  in_f, out_f;
  int          n_fail, checked;

  mwl_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  mwl_latch u_dut (.clk(clk), .rst(rst), .boot_strap_select(strap),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_tick(tick),
    .x_data(xd), .y_data(yd), .z_data(zd), .upper_threshold(uth),
    .lower_threshold(lth), .inside_debounce_count(idb),
    .outside_debounce_count(odb), .inside_logic_select(lsel),
    .inside_window_event_active(in_ea),
    .outside_window_event_active(out_ea),
    .axis_inside_window_flags(in_f), .axis_outside_window_flags(out_f),
    .change_detect_axis_latch_config(cfg));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic do_reset(input logic s);
    rst   <= 1'b1;
    strap <= s;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // one evaluation; outputs move in the cycle after the tick
  task automatic smp(input logic [11:0] x, y, z);
    @(posedge clk);
    xd   <= x;
    yd   <= y;
    zd   <= z;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ck_in(input logic ea, input logic [2:0] f);
    chk({4'h0, in_ea, in_f}, {4'h0, ea, f});
  endtask

  task automatic ck_out(input logic ea, input logic [2:0] f);
    chk({4'h0, out_ea, out_f}, {4'h0, ea, f});
  endtask

  task automatic t_cfg();
    do_reset(1'b1);
    chk(cfg, 8'h38);
    u_host.rd(mwl_pkg::CFG_ADDR);
    chk(u_host.rd_data, 8'h38);
    do_reset(1'b0);
    chk(cfg, 8'h00);
    u_host.wr(mwl_pkg::CFG_ADDR, 8'h5a);
    u_host.wr(mwl_pkg::IN_SRC_ADDR, 8'hff);
    u_host.rd(mwl_pkg::CFG_ADDR);
    chk(u_host.rd_data, 8'h5a);
    u_host.rd(8'h10);
    chk(u_host.rd_data, 8'h00);
  endtask

  task automatic t_in_latch();
    u_host.wr(mwl_pkg::CFG_ADDR, 8'h47);
    smp(IN, UP, LO);
    ck_in(1'b1, 3'b100);
    u_host.rd(mwl_pkg::IN_SRC_ADDR);
    chk(u_host.rd_data, 8'ha0);
    ck_in(1'b0, 3'b000);
    smp(IN, UP, LO);
    ck_in(1'b0, 3'b000);
    smp(OUT, OUT, OUT);
    smp(IN, UP, IN);
    ck_in(1'b1, 3'b101);
    smp(OUT, OUT, OUT);
    ck_in(1'b1, 3'b101);
    u_host.rd(mwl_pkg::IN_SRC_ADDR);
    chk(u_host.rd_data, 8'ha2);
  endtask

  task automatic t_in_track();
    u_host.wr(mwl_pkg::CFG_ADDR, 8'h07);
    smp(IN, UP, IN);
    ck_in(1'b1, 3'b101);
    smp(OUT, OUT, OUT);
    ck_in(1'b0, 3'b000);
    // all-logic with no axis enabled would fire without the disable
    lsel <= 1'b1;
    u_host.wr(mwl_pkg::CFG_ADDR, 8'h40);
    smp(IN, IN, IN);
    chk({7'h0, in_ea}, 8'h00);
    u_host.wr(mwl_pkg::CFG_ADDR, 8'h00);
    smp(IN, IN, IN);
    chk({7'h0, in_ea}, 8'h00);
    u_host.wr(mwl_pkg::CFG_ADDR, 8'h05);
    smp(IN, OUT, OUT);
    ck_in(1'b0, 3'b100);
    smp(IN, OUT, IN);
    ck_in(1'b1, 3'b101);
    lsel <= 1'b0;
    idb  <= 8'h02;
    smp(OUT, OUT, OUT);
    ck_in(1'b0, 3'b101);
    smp(IN, IN, IN);
    ck_in(1'b0, 3'b101);
    smp(IN, IN, IN);
    ck_in(1'b1, 3'b111);
    idb  <= 8'h00;
  endtask

  task automatic t_out();
    u_host.wr(mwl_pkg::CFG_ADDR, 8'ha8);
    smp(OUT, OUT, IN);
    ck_out(1'b1, 3'b100);
    smp(IN, IN, IN);
    ck_out(1'b1, 3'b100);
    u_host.rd(mwl_pkg::OUT_SRC_ADDR);
    chk(u_host.rd_data, 8'ha0);
    ck_out(1'b0, 3'b000);
    smp(UP, IN, IN);
    ck_out(1'b1, 3'b100);
    u_host.rd(mwl_pkg::OUT_SRC_ADDR);
    chk(u_host.rd_data, 8'ha0);
    smp(OUT, IN, IN);
    chk({7'h0, out_ea}, 8'h00);
    u_host.wr(mwl_pkg::CFG_ADDR, 8'h38);
    smp(OUT, LO, IN);
    ck_out(1'b1, 3'b110);
    smp(IN, IN, IN);
    ck_out(1'b0, 3'b000);
  endtask

  initial begin
    n_fail  = 0;
    checked = 0;
    rst = 1'b1;
    strap = 1'b0;
    tick = 1'b0;
    lsel = 1'b0;
    xd = IN;
    yd = IN;
    zd = IN;
    uth = UP;
    lth = LO;
    idb = 8'h00;
    odb = 8'h00;
    t_cfg();
    t_in_latch();
    t_in_track();
    t_out();
    end_sim();
  end

  // the whole sequence takes well under a thousand cycles
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
endmodule
